// ---- rtl/etc_pkg.sv ----
package etc_pkg;
    // Register addresses on the parallel bus; high shares one address with the mode.
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h09;
    localparam logic [7:0] ADDR_COUNT_MID = 8'h0A;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0B;
    localparam logic [7:0] ADDR_MODE = 8'h0B;
    // The page select level tells the count register from the mode register at the shared address.
    localparam logic PAGE_COUNT = 1'b0;
    localparam logic PAGE_MODE = 1'b1;
    // Mode codes written into the mode select register.
    localparam logic [7:0] MODE_STOP = 8'h00;
    localparam logic [7:0] MODE_HOLD_HI = 8'h05;
    localparam logic [7:0] MODE_HI_NOW = 8'h61;
    localparam logic [7:0] MODE_SPLIT = 8'h65;
    localparam logic [7:0] MODE_FULL = 8'h68;
    localparam logic [7:0] MODE_HI_START = 8'h71;
    // Reset value of every register and of the read data bus.
    localparam logic [7:0] REG_RESET = 8'h00;
    // Counter width and the padding used to widen narrower load values.
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    localparam logic [15:0] PAD16 = 16'h0000;
    localparam logic [7:0] PAD8 = 8'h00;
    // Bus pins as one bundle so that they pass the synchroniser together.
    typedef struct packed {
        logic page;
        logic [7:0] addr;
        logic [7:0] data;
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } etc_bus_s;
    // Start-bit arming state of each counter.
    typedef enum logic [2:0] {
        ARM_IDLE = 3'b001,
        ARM_WAIT = 3'b010,
        ARM_RUN = 3'b100
    } etc_arm_e;
endpackage

// ---- rtl/etc_cnt_if.sv ----
`timescale 1ns/1ns
// Control and status between the mode logic and one down counter.
interface etc_cnt_if;
    logic load; // Load the value and start counting.
    logic stop; // Stop and clear the count.
    logic auto_reload; // Restart the same count after terminal count.
    logic tick; // One ETU has elapsed.
    logic [etc_pkg::CNT_W-1:0] load_val; // Number of ETUs to count.
    logic [etc_pkg::CNT_W-1:0] count; // Remaining ETUs.
    logic running; // The counter is counting.
    logic tc; // Terminal count pulse.
    modport ctrl (output load, stop, auto_reload, tick, load_val, input count, running, tc);
    modport cnt (input load, stop, auto_reload, tick, load_val, output count, running, tc);
endinterface

// ---- rtl/etc_down_counter.sv ----
`timescale 1ns/1ns
// ETU down counter, used both as the 8-bit reload counter and the 16/24-bit counter.
module etc_down_counter (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    etc_cnt_if.cnt cif
);
    logic [etc_pkg::CNT_W-1:0] cnt_r; // Remaining ETUs.
    logic [etc_pkg::CNT_W-1:0] val_r; // Value copied at load, used for reloads.
    logic run_r; // Counting.
    logic rld_r; // Auto-reload enabled.
    logic at_end; // The tick in this cycle ends the count.

    assign at_end = run_r && cif.tick && (cnt_r == etc_pkg::CNT_ONE);
    // A load or stop in the same cycle overrides the end of count.
    assign cif.tc = at_end && !cif.load && !cif.stop;
    assign cif.count = cnt_r;
    assign cif.running = run_r;

    // The reload value is a private copy, so later register writes leave the running count alone.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            val_r <= etc_pkg::CNT_ZERO;
            rld_r <= 1'b0;
        end
        else if (cif.load)
        begin
            val_r <= cif.load_val; // RULE_19
            rld_r <= cif.auto_reload;
        end
    end

    // Count down once per ETU; a zero load leaves the counter stopped.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            cnt_r <= etc_pkg::CNT_ZERO;
            run_r <= 1'b0;
        end
        else if (cif.load)
        begin
            cnt_r <= cif.load_val;
            run_r <= (cif.load_val != etc_pkg::CNT_ZERO);
        end
        else if (cif.stop)
        begin
            cnt_r <= etc_pkg::CNT_ZERO;
            run_r <= 1'b0;
        end
        else if (at_end)
        begin
            // Reload repeats the same count; otherwise the counter halts.
            cnt_r <= rld_r ? val_r : etc_pkg::CNT_ZERO; // RULE_12
            run_r <= rld_r;
        end
        else if (run_r && cif.tick)
        begin
            cnt_r <= cnt_r - etc_pkg::CNT_ONE;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    // A reloading counter starts over with the loaded value right after terminal count.
    property p_cnt_reload;
        cif.tc && rld_r |=> run_r && (cnt_r == $past(val_r));
    endproperty
    a_cnt_reload: assert property (p_cnt_reload) else $error("reload missed"); // RULE_12

    // Terminal count only comes when the counter was running or loading the cycle before.
    property p_cnt_tc_cause;
        cif.tc |-> $past(run_r) || $past(cif.load);
    endproperty
    a_cnt_tc_cause: assert property (p_cnt_tc_cause) else $error("stray tc"); // RULE_01
endmodule

// ---- rtl/etc_top.sv ----
`timescale 1ns/1ns
// Summary of operation
// RULE_01: Three byte registers form 24-bit or 16+8 counters.
// RULE_02: Loaded value counts ETUs, low byte first.
// RULE_03: Host uses counters only with active clocked card.
// RULE_04: Reset clears count and mode registers.
// RULE_05: Host writes only defined mode codes.
// RULE_06: Mode 00H stops all counters.
// RULE_07: Mode 05H stops upper pair, short keeps running.
// RULE_08: Mode 61H starts 16-bit counter at once.
// RULE_09: 61H terminal count sets long flag, interrupt.
// RULE_10: Host stops 61H counter before reloading.
// RULE_11: 65H short counter starts at first START.
// RULE_12: Short terminal count flags, interrupts, then reloads.
// RULE_13: Host leaves low register alone while reloading.
// RULE_14: 65H long counter starts at write, flags.
// RULE_15: Host writes 05H before reloading upper pair.
// RULE_16: Mode 68H starts 24-bit counter at once.
// RULE_17: Host leaves registers alone during 68H count.
// RULE_18: 71H long counter restarts on every START.
// RULE_19: Upper rewrite waits for the next START.
// RULE_20: Host keeps registers nonzero in 71H.
// RULE_21: Host writes 00H before restarting long counters.
// RULE_22: 71H terminal count sets long flag, interrupt.
// RULE_23: 68H terminal count sets long flag, interrupt.
module etc_top (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic page_sel_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    input wire logic etu_tick_i,
    input wire logic start_bit_i,
    input wire logic usr_read_i,
    output logic short_timer_flag_o,
    output logic long_timer_flag_o,
    output logic irq_o
);
    etc_pkg::etc_bus_s bus_s1_r; // First synchroniser stage, read only by the second.
    etc_pkg::etc_bus_s bus_s2_r; // Second synchroniser stage.
    etc_pkg::etc_bus_s bus_s3_r; // Delayed copy for edge detection and stable address and data.
    logic wr_evt; // End of a write strobe to this chip.
    logic rd_act; // A read strobe to this chip is active.
    logic cfg_wr; // Write to the mode select register.
    logic cnt_wr; // Write to the count register page, at any address.
    logic [7:0] mode_r; // Mode select register.
    logic [7:0] low_r; // Count bits 7..0.
    logic [7:0] mid_r; // Count bits 15..8.
    logic [7:0] high_r; // Count bits 23..16.
    etc_pkg::etc_arm_e lo_arm_r; // Arming of the short counter.
    etc_pkg::etc_arm_e lo_arm_nxt;
    etc_pkg::etc_arm_e hi_arm_r; // Arming of the long counter in START-bit mode.
    etc_pkg::etc_arm_e hi_arm_nxt;
    logic short_nxt;
    logic long_nxt;
    logic hi_start_now; // Mode codes that start the long counter at the write.

    etc_cnt_if lo_if ();
    etc_cnt_if hi_if ();

    etc_down_counter u_lo (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .cif(lo_if.cnt)
    );

    etc_down_counter u_hi (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .cif(hi_if.cnt)
    );

    // Bus pins come from the host's timing, so they pass two flip-flops before use.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            bus_s1_r <= '1;
            bus_s2_r <= '1;
            bus_s3_r <= '1;
        end
        else
        begin
            bus_s1_r <= {page_sel_i, addr_i, data_i, cs_n_i, wr_n_i, rd_n_i};
            bus_s2_r <= bus_s1_r;
            bus_s3_r <= bus_s2_r;
        end
    end

    // The write takes effect at the rising strobe; address and data come from the stage before it.
    assign wr_evt = bus_s2_r.wr_n && !bus_s3_r.wr_n && !bus_s3_r.cs_n;
    assign rd_act = !bus_s2_r.rd_n && !bus_s2_r.cs_n;
    assign cfg_wr = wr_evt && (bus_s3_r.page == etc_pkg::PAGE_MODE)
        && (bus_s3_r.addr == etc_pkg::ADDR_MODE);
    assign cnt_wr = wr_evt && (bus_s3_r.page == etc_pkg::PAGE_COUNT);
    assign hi_start_now = (bus_s3_r.data == etc_pkg::MODE_HI_NOW)
        || (bus_s3_r.data == etc_pkg::MODE_SPLIT) || (bus_s3_r.data == etc_pkg::MODE_FULL);

    // Count registers are write only; a rewrite never disturbs a running count.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            low_r <= etc_pkg::REG_RESET; // RULE_04
            mid_r <= etc_pkg::REG_RESET;
            high_r <= etc_pkg::REG_RESET;
        end
        else if (cnt_wr)
        begin
            // The three bytes of the count, low byte at the lowest address.
            if (bus_s3_r.addr == etc_pkg::ADDR_COUNT_LOW)
                low_r <= bus_s3_r.data; // RULE_02
            if (bus_s3_r.addr == etc_pkg::ADDR_COUNT_MID)
                mid_r <= bus_s3_r.data;
            if (bus_s3_r.addr == etc_pkg::ADDR_COUNT_HIGH)
                high_r <= bus_s3_r.data;
        end
    end

    // The mode register stores whatever is written; codes outside the set act as a stop.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
            mode_r <= etc_pkg::REG_RESET; // RULE_04
        else if (cfg_wr)
            mode_r <= bus_s3_r.data;
    end

    // Arming of the short counter: waits for a START bit after the split-mode write.
    always_comb
    begin
        lo_arm_nxt = lo_arm_r;
        if (cfg_wr)
        begin
            case (bus_s3_r.data)
                etc_pkg::MODE_SPLIT: lo_arm_nxt = etc_pkg::ARM_WAIT;
                etc_pkg::MODE_HOLD_HI: lo_arm_nxt = lo_arm_r; // RULE_07
                default: lo_arm_nxt = etc_pkg::ARM_IDLE;
            endcase
        end
        else
        begin
            case (lo_arm_r)
                etc_pkg::ARM_WAIT: if (start_bit_i) lo_arm_nxt = etc_pkg::ARM_RUN; // RULE_11
                etc_pkg::ARM_RUN: lo_arm_nxt = etc_pkg::ARM_RUN;
                default: lo_arm_nxt = etc_pkg::ARM_IDLE;
            endcase
        end
    end

    // Arming of the long counter in START-bit mode: every START bit restarts it.
    always_comb
    begin
        hi_arm_nxt = hi_arm_r;
        if (cfg_wr)
        begin
            case (bus_s3_r.data)
                etc_pkg::MODE_HI_START: hi_arm_nxt = etc_pkg::ARM_WAIT;
                default: hi_arm_nxt = etc_pkg::ARM_IDLE;
            endcase
        end
        else
        begin
            case (hi_arm_r)
                etc_pkg::ARM_WAIT: if (start_bit_i) hi_arm_nxt = etc_pkg::ARM_RUN;
                etc_pkg::ARM_RUN: hi_arm_nxt = etc_pkg::ARM_RUN;
                default: hi_arm_nxt = etc_pkg::ARM_IDLE;
            endcase
        end
    end

    // Both arming machines idle after reset, so nothing counts.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            lo_arm_r <= etc_pkg::ARM_IDLE;
            hi_arm_r <= etc_pkg::ARM_IDLE;
        end
        else
        begin
            lo_arm_r <= lo_arm_nxt;
            hi_arm_r <= hi_arm_nxt;
        end
    end

    // Short counter: loads the low byte on the first START bit and reloads itself.
    assign lo_if.tick = etu_tick_i;
    assign lo_if.auto_reload = 1'b1; // RULE_12
    assign lo_if.load_val = {etc_pkg::PAD16, low_r};
    assign lo_if.load = !cfg_wr && (lo_arm_r == etc_pkg::ARM_WAIT) && start_bit_i; // RULE_11
    // Every mode but the hold code stops the short counter.
    assign lo_if.stop = cfg_wr && (bus_s3_r.data != etc_pkg::MODE_HOLD_HI); // RULE_06

    // Long counter: 24 bits in full mode, upper two bytes otherwise.
    assign hi_if.tick = etu_tick_i;
    assign hi_if.auto_reload = 1'b0;
    assign hi_if.load_val = (cfg_wr && (bus_s3_r.data == etc_pkg::MODE_FULL))
        ? {high_r, mid_r, low_r} : {etc_pkg::PAD8, high_r, mid_r}; // RULE_01 RULE_16
    assign hi_if.load = (cfg_wr && hi_start_now) // RULE_08 RULE_14
        || (!cfg_wr && (hi_arm_r != etc_pkg::ARM_IDLE) && start_bit_i); // RULE_18 RULE_19
    assign hi_if.stop = cfg_wr && !hi_start_now; // RULE_06 RULE_07

    // Flags are sticky until the status read; a terminal count in that cycle still sets them.
    assign short_nxt = lo_if.tc || (short_timer_flag_o && !usr_read_i); // RULE_12
    assign long_nxt = hi_if.tc || (long_timer_flag_o && !usr_read_i); // RULE_09 RULE_22 RULE_23

    // The interrupt follows the flags in the same cycle.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            short_timer_flag_o <= 1'b0;
            long_timer_flag_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            short_timer_flag_o <= short_nxt;
            long_timer_flag_o <= long_nxt;
            irq_o <= short_nxt || long_nxt;
        end
    end

    // Only the mode register reads back; the write-only count bytes read as zero.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            data_o <= etc_pkg::REG_RESET;
            data_oe_n_o <= 1'b1;
        end
        else
        begin
            data_oe_n_o <= !rd_act;
            if (rd_act && (bus_s2_r.page == etc_pkg::PAGE_MODE)
                && (bus_s2_r.addr == etc_pkg::ADDR_MODE))
                data_o <= mode_r;
            else
                data_o <= etc_pkg::REG_RESET;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_cfg(logic [7:0] code);
        cfg_wr && (bus_s3_r.data == code);
    endsequence

    sequence s_lo_first_start;
        !cfg_wr && (lo_arm_r == etc_pkg::ARM_WAIT) && start_bit_i && (low_r != etc_pkg::PAD8);
    endsequence

    property p_reset_clear;
        disable iff (1'b0) !rstn_i |=> (mode_r == etc_pkg::REG_RESET) && !irq_o
            && (low_r == etc_pkg::REG_RESET) && (high_r == etc_pkg::REG_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong"); // RULE_04

    property p_stop_all;
        s_cfg(etc_pkg::MODE_STOP) |=> (!lo_if.running && !hi_if.running) [*2];
    endproperty
    a_stop_all: assert property (p_stop_all) else $error("stop left a counter on"); // RULE_06

    property p_hold_hi;
        s_cfg(etc_pkg::MODE_HOLD_HI) |=> !hi_if.running && (lo_if.running == $past(lo_if.running));
    endproperty
    a_hold_hi: assert property (p_hold_hi) else $error("hold mode wrong"); // RULE_07

    property p_hi_now;
        s_cfg(etc_pkg::MODE_HI_NOW) |=> !lo_if.running
            && (hi_if.count == {etc_pkg::PAD8, $past(high_r), $past(mid_r)});
    endproperty
    a_hi_now: assert property (p_hi_now) else $error("16-bit start wrong"); // RULE_08

    property p_lo_start;
        s_lo_first_start |=> lo_if.running && (lo_if.count == {etc_pkg::PAD16, $past(low_r)});
    endproperty
    a_lo_start: assert property (p_lo_start) else $error("short start missed"); // RULE_11

    property p_short_flag;
        lo_if.tc |=> short_timer_flag_o && irq_o && lo_if.running;
    endproperty
    a_short_flag: assert property (p_short_flag) else $error("short tc lost"); // RULE_12

    property p_long_flag;
        hi_if.tc |=> long_timer_flag_o && irq_o;
    endproperty
    a_long_flag: assert property (p_long_flag) else $error("long tc lost"); // RULE_09

    property p_full_now;
        s_cfg(etc_pkg::MODE_FULL) |=> !lo_if.running
            && (hi_if.count == {$past(high_r), $past(mid_r), $past(low_r)});
    endproperty
    a_full_now: assert property (p_full_now) else $error("24-bit start wrong"); // RULE_16

    property p_start_restart;
        !cfg_wr && (hi_arm_r != etc_pkg::ARM_IDLE) && start_bit_i
            |=> hi_if.count == {etc_pkg::PAD8, $past(high_r), $past(mid_r)};
    endproperty
    a_start_restart: assert property (p_start_restart) else $error("START restart missed"); // RULE_18

    property p_flag_quiet;
        !long_timer_flag_o && !hi_if.tc |=> !long_timer_flag_o;
    endproperty
    a_flag_quiet: assert property (p_flag_quiet) else $error("long flag without cause"); // RULE_22
endmodule

// ---- sim/etc_host_model.sv ----
`timescale 1ns/1ns
// Host model: drives the parallel register bus with full strobe spacing.
module etc_host_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] data_o_i,
    output logic cs_n_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic page_o,
    output logic [7:0] addr_o,
    output logic [7:0] data_bus_o
);
    // Release the bus; address and data are inverted so a stale value never looks valid.
    task automatic release_bus();
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        addr_o = ~addr_o;
        data_bus_o = ~data_bus_o;
    endtask

    // The bus idles from time zero, since the card clock always runs here.
    initial
    begin
        page_o = 1'b0;
        addr_o = 8'h00;
        data_bus_o = 8'h00;
        release_bus();
    end

    // Write: strobe low for four cycles, then address and data held three more.
    // The extra hold matters because the block samples the pins through three flops.
    task automatic write_reg(input logic pg, input logic [7:0] adr, input logic [7:0] dat);
        page_o = pg;
        addr_o = adr;
        data_bus_o = dat;
        cs_n_o = 1'b0;
        wr_n_o = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        wr_n_o = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        release_bus();
        repeat (4) @(negedge sys_clk_i);
    endtask

    // Read: strobe held until the answer has settled, data taken at that edge.
    task automatic read_reg(input logic pg, input logic [7:0] adr, output logic [7:0] dat);
        page_o = pg;
        addr_o = adr;
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        dat = data_o_i;
        @(negedge sys_clk_i);
        release_bus();
        repeat (4) @(negedge sys_clk_i);
    endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
// Self-checking bench for the time-out counter block.
module testbench;
    localparam int PERIOD = 50;
    localparam int LIMIT = 20000; // Well above the fewer than two thousand cycles the run needs.
    localparam int K_READ = 0;
    localparam int K_SHORT = 1;
    localparam int K_LONG = 2;
    // One expected result: its kind and, for reads, the data byte.
    typedef struct {
        int kind;
        logic [7:0] val;
    } etc_note_s;
    logic sys_clk_i;
    logic rstn_i;
    logic cs_n_i;
    logic wr_n_i;
    logic rd_n_i;
    logic page_sel_i;
    logic [7:0] addr_i;
    logic [7:0] data_i;
    logic [7:0] data_o;
    logic data_oe_n_o;
    logic etu_tick_i;
    logic start_bit_i;
    logic usr_read_i;
    logic short_timer_flag_o;
    logic long_timer_flag_o;
    logic irq_o;
    etc_note_s note_q[$]; // Results the driver expects, oldest first.
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int len_short;
    logic prev_short = 1'b0;
    logic prev_long = 1'b0;
    logic prev_oe = 1'b1;
    logic [7:0] rd_val;
    // The defined non-stop mode codes, each written, read back and stopped in turn.
    logic [7:0] codes [5] = '{etc_pkg::MODE_HOLD_HI, etc_pkg::MODE_HI_NOW,
        etc_pkg::MODE_SPLIT, etc_pkg::MODE_FULL, etc_pkg::MODE_HI_START};

    // Free-running system clock.
    initial
    begin
        sys_clk_i = 1'b0;
        forever #(PERIOD / 2) sys_clk_i = ~sys_clk_i;
    end

    etc_top etc_top_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
        .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .page_sel_i(page_sel_i), .addr_i(addr_i),
        .data_i(data_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
        .etu_tick_i(etu_tick_i), .start_bit_i(start_bit_i), .usr_read_i(usr_read_i),
        .short_timer_flag_o(short_timer_flag_o), .long_timer_flag_o(long_timer_flag_o),
        .irq_o(irq_o));

    etc_host_model etc_host_model_inst (.sys_clk_i(sys_clk_i), .data_o_i(data_o),
        .cs_n_o(cs_n_i), .wr_n_o(wr_n_i), .rd_n_o(rd_n_i), .page_o(page_sel_i),
        .addr_o(addr_i), .data_bus_o(data_i));

    // Prints the verdict and ends the run; also reached from the timeout.
    task automatic summarize();
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Counts one comparison and reports it at once if it differs.
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Matches one observed result against the oldest note.
    task automatic take(input int kind, input logic [7:0] val);
        etc_note_s n;
        if (note_q.size() == 0)
        begin
            check("unexpected result kind", 24'hFFFFFF, 24'(kind));
        end
        else
        begin
            n = note_q.pop_front();
            check("result kind", 24'(n.kind), 24'(kind));
            check("result data", {16'h0000, n.val}, {16'h0000, val});
            if (kind != K_READ)
                check("irq with flag", 24'h000001, {23'h000000, irq_o});
        end
    endtask

    // Watcher: a rising flag or a starting read answer is a result.
    always @(posedge sys_clk_i)
    begin
        if (rstn_i === 1'b1)
        begin
            if (short_timer_flag_o === 1'b1 && prev_short !== 1'b1)
                take(K_SHORT, 8'h00);
            if (long_timer_flag_o === 1'b1 && prev_long !== 1'b1)
                take(K_LONG, 8'h00);
            if (data_oe_n_o === 1'b0 && prev_oe !== 1'b0)
                take(K_READ, data_o);
        end
        prev_short <= short_timer_flag_o;
        prev_long <= long_timer_flag_o;
        prev_oe <= data_oe_n_o;
    end

    // Guard against a hang.
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic wr(input logic pg, input logic [7:0] adr, input logic [7:0] dat);
        etc_host_model_inst.write_reg(pg, adr, dat);
    endtask

    // Reads a register, noting the byte the watcher must see.
    task automatic rd(input logic pg, input logic [7:0] adr, input logic [7:0] exp);
        note_q.push_back('{K_READ, exp});
        etc_host_model_inst.read_reg(pg, adr, rd_val);
        check("read data", {16'h0000, exp}, {16'h0000, rd_val});
    endtask

    // Only defined mode codes are ever written.
    task automatic mode(input logic [7:0] code);
        wr(etc_pkg::PAGE_MODE, etc_pkg::ADDR_MODE, code);
    endtask

    // Loads the three count bytes, high first.
    task automatic set_count(input logic [7:0] hi, input logic [7:0] mid, input logic [7:0] lo);
        wr(etc_pkg::PAGE_COUNT, etc_pkg::ADDR_COUNT_HIGH, hi);
        wr(etc_pkg::PAGE_COUNT, etc_pkg::ADDR_COUNT_MID, mid);
        wr(etc_pkg::PAGE_COUNT, etc_pkg::ADDR_COUNT_LOW, lo);
    endtask

    // ETU pulses with random gaps; back-to-back ticks keep the line high.
    task automatic ticks(input int n);
        repeat (n)
        begin
            etu_tick_i = 1'b1;
            @(negedge sys_clk_i);
            if ($urandom % 2 == 1)
            begin
                etu_tick_i = 1'b0;
                @(negedge sys_clk_i);
            end
        end
        etu_tick_i = 1'b0;
        @(negedge sys_clk_i);
    endtask

    task automatic start_pulse();
        start_bit_i = 1'b1;
        @(negedge sys_clk_i);
        start_bit_i = 1'b0;
        @(negedge sys_clk_i);
    endtask

    // Status read clears both flags and the interrupt.
    task automatic clear_flags();
        usr_read_i = 1'b1;
        @(negedge sys_clk_i);
        usr_read_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        check("flags after clear", 24'h000000,
            {21'h000000, short_timer_flag_o, long_timer_flag_o, irq_o});
    endtask

    // A flag may only rise on the n-th tick: the note goes in just before it.
    task automatic fire(input int n, input int kind);
        if (n > 1)
            ticks(n - 1);
        note_q.push_back('{kind, 8'h00});
        ticks(1);
        repeat (3) @(negedge sys_clk_i);
        check("pending results", 24'h000000, 24'(note_q.size()));
        clear_flags();
    endtask

    initial
    begin
        rstn_i = 1'b0;
        etu_tick_i = 1'b0;
        start_bit_i = 1'b0;
        usr_read_i = 1'b0;
        void'($urandom(56));
        repeat (6) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        @(negedge sys_clk_i);
        check("oe and irq after reset", 24'h000002, {22'h000000, data_oe_n_o, irq_o});
        rd(etc_pkg::PAGE_MODE, etc_pkg::ADDR_MODE, etc_pkg::REG_RESET);
        wr(etc_pkg::PAGE_COUNT, etc_pkg::ADDR_COUNT_LOW, 8'h5A);
        rd(etc_pkg::PAGE_COUNT, etc_pkg::ADDR_COUNT_LOW, etc_pkg::REG_RESET);
        // Every defined code reads back, each followed by a stop.
        foreach (codes[i])
        begin
            mode(codes[i]);
            rd(etc_pkg::PAGE_MODE, etc_pkg::ADDR_MODE, codes[i]);
            mode(etc_pkg::MODE_STOP);
        end
        mode(etc_pkg::MODE_HI_NOW);
        rd(etc_pkg::PAGE_MODE, etc_pkg::ADDR_MODE, etc_pkg::MODE_HI_NOW);
        mode(etc_pkg::MODE_STOP);
        wr(etc_pkg::PAGE_COUNT, 8'h0C, 8'hFF);
        rd(etc_pkg::PAGE_MODE, 8'h0C, etc_pkg::REG_RESET);
        rd(etc_pkg::PAGE_MODE, etc_pkg::ADDR_MODE, etc_pkg::MODE_STOP);
        // Immediate 16-bit count from {high, mid}; the low byte must stay idle.
        set_count(8'h01, 8'h02, 8'h03);
        mode(etc_pkg::MODE_HI_NOW);
        fire(258, K_LONG);
        ticks(8);
        mode(etc_pkg::MODE_STOP);
        // Split mode: long starts on the write, short waits for a START bit.
        len_short = 2 + $urandom % 4;
        set_count(8'h00, 8'h05, 8'(len_short));
        mode(etc_pkg::MODE_SPLIT);
        fire(5, K_LONG);
        ticks(8);
        start_pulse();
        fire(len_short, K_SHORT);
        ticks(1);
        start_pulse();
        fire(len_short - 1, K_SHORT);
        mode(etc_pkg::MODE_HOLD_HI);
        fire(len_short, K_SHORT);
        mode(etc_pkg::MODE_STOP);
        ticks(2 * len_short);
        mode(etc_pkg::MODE_SPLIT);
        mode(etc_pkg::MODE_HOLD_HI);
        ticks(8);
        start_pulse();
        fire(len_short, K_SHORT);
        mode(etc_pkg::MODE_STOP);
        // One 24-bit count; a 16-bit reading of it would fire far too early.
        set_count(8'h00, 8'h01, 8'h03);
        mode(etc_pkg::MODE_FULL);
        fire(259, K_LONG);
        mode(etc_pkg::MODE_STOP);
        // START-triggered 16-bit count, restarted by every START bit.
        set_count(8'h00, 8'h04, 8'h00);
        mode(etc_pkg::MODE_HI_START);
        ticks(6);
        start_pulse();
        ticks(2);
        start_pulse();
        fire(4, K_LONG);
        start_pulse();
        ticks(1);
        wr(etc_pkg::PAGE_COUNT, etc_pkg::ADDR_COUNT_MID, 8'h06);
        fire(3, K_LONG);
        start_pulse();
        fire(6, K_LONG);
        mode(etc_pkg::MODE_STOP);
        summarize();
    end
endmodule
